// >>> rtl/sound_gen_map.vh
`ifndef SOUND_GEN_MAP_VH
`define SOUND_GEN_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CONTROL          5'h00
`define OFS_ENVELOPE         5'h01
`define OFS_DIVIDER_HIGH     5'h02
`define OFS_DIVIDER_LOW      5'h03
`define OFS_TONE_HIGH        5'h04
`define OFS_TONE_LOW         5'h05
`define OFS_AMP_HIGH         5'h06
`define OFS_AMP_LOW          5'h07
`define OFS_STEP_HIGH        5'h08
`define OFS_STEP_LOW         5'h09
`define OFS_THRESHOLD_HIGH   5'h0a
`define OFS_THRESHOLD_LOW    5'h0b
`define OFS_SPAN_LENGTH      5'h0c
`define OFS_IRQ_ENABLE       5'h0d
`define OFS_IRQ_FLAG         5'h0e
`define OFS_LIVE_AMP_HIGH    5'h10
`define OFS_LIVE_AMP_LOW     5'h11
`define OFS_SPAN_COUNTER     5'h12
// ****************************************
// Field positions
// ****************************************
`define BIT_STOP             0
`define BIT_READY            1
`define BIT_ENABLE           7
`define BIT_DIRECTION        0
`define BIT_SHAPE_LO         1
`define BIT_SHAPE_HI         2
`define BIT_ENVELOPE_ENABLE  7
`define BIT_NEXT_DATA        0
// ****************************************
// Shape encodings and reset values
// ****************************************
`define SHAPE_LINEAR         2'h0
`define SHAPE_GONG           2'h1
`define SHAPE_EXPONENTIAL    2'h2
`define RESET_BYTE           8'h00
`define RESET_WORD11         11'h000
`define AMP_MAX              11'h7ff
`define GONG_MAX             16'hffff
`endif

// >>> rtl/sound_amplitude_tone_gen.v
// Strobed register access is this design's own decision.
`include "sound_gen_map.vh"

// Contract
// RULE1: Step value sets linear envelope increment
// RULE2: Threshold reached by >= attack, <= decay
// RULE3: One span is length plus one cycles
// RULE4: Envelope steps once per completed span
// RULE5: No envelope: span end reloads or stops
// RULE6: Interrupt while enable and flag set
// RULE7: Flag sets on load or stopped reload
// RULE8: Writing one clears flag, zero ignored
// RULE9: Live amplitude buffer alone drives output
// RULE10: Span counter advances on tone falling edge
// RULE11: Span counter wraps at length, zero when stopped
// RULE12: PWM duty is buffer over divider plus one
// RULE13: Amplitude writes wait for next reload
// RULE14: Tone half period is tone plus one ticks
// RULE15: Shape select linear, gong, exponential
// RULE16: Direction attack zero, decay one; gated
// RULE17: Config writes clear ready; zero stops
// RULE18: Divider splits clock by value plus one
module sound_amplitude_tone_gen #(
    parameter ADDR_W = 5
) (
    input  wire              sys_clk,
    input  wire              reset_n,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_write,
    input  wire              reg_read,
    output reg  [7:0]        reg_rdata,
    output wire              irq,
    output wire              amp_pwm,
    output wire              tone_out,
    output wire              running_out
);

// ****************************************
// Configuration registers
// ****************************************
reg        gen_enable;
reg        stop_req;
reg        config_ready_bit;
reg        envelope_enable;
reg  [1:0] envelope_shape_select;
reg        envelope_direction;
reg  [7:0] tone_span_length;
reg        next_data_irq_enable;
reg        next_data_ready_flag;

// Word registers split over a high and a low byte
wire [10:0] clock_divider;
wire  [9:0] half_tone_period;
wire [10:0] amplitude_config;
wire [10:0] amplitude_step;
wire [10:0] amplitude_threshold;

// ****************************************
// Working buffers and counters
// ****************************************
reg        running;
reg        env_en_buf;
reg  [1:0] shape_buf;
reg        dir_buf;
reg [10:0] divider_buf;
reg  [9:0] tone_buf;
reg [10:0] live_amplitude;
reg [10:0] step_buf;
reg [10:0] threshold_buf;
reg  [7:0] span_buf;
reg [15:0] gong_acc;
reg [10:0] divider_count;
reg  [9:0] tone_count;
reg        tone_level;
reg  [7:0] tone_span_counter;

wire       write_hit = reg_write;
wire       is_config_write = write_hit && (reg_addr >= `OFS_ENVELOPE) && (reg_addr <= `OFS_SPAN_LENGTH);
wire       may_run = gen_enable && !stop_req;
wire       divider_tick = running && (divider_count == divider_buf);          // [RULE18]
wire       tone_wrap = divider_tick && (tone_count == tone_buf);              // [RULE14]
wire       tone_fall = tone_wrap && tone_level;                               // [RULE10]
wire       span_done = tone_fall && (tone_span_counter == span_buf);          // [RULE3] [RULE11]

// ****************************************
// Envelope arithmetic
// ****************************************
reg [11:0] wide_amp;
reg [16:0] wide_gong;
reg [15:0] next_gong_acc;
reg [10:0] next_amp;
reg        threshold_hit;

always @* begin
    wide_amp = 12'h000;
    wide_gong = 17'h00000;
    next_gong_acc = gong_acc;
    next_amp = live_amplitude;
    case (shape_buf)                                                          // [RULE15]
        `SHAPE_LINEAR: begin
            if (!dir_buf) begin                                               // [RULE16]
                wide_amp = {1'b0, live_amplitude} + {1'b0, step_buf};         // [RULE1]
                next_amp = wide_amp[11] ? `AMP_MAX : wide_amp[10:0];
            end else begin
                next_amp = (live_amplitude > step_buf) ? (live_amplitude - step_buf) : `RESET_WORD11; // [RULE1]
            end
        end
        `SHAPE_GONG: begin
            // Accumulator keeps five fraction bits so small amplitudes still move
            if (!dir_buf) begin
                // Saturate: a wrapped sum would drop the amplitude and miss a high threshold
                wide_gong = {1'b0, gong_acc} + {6'h00, gong_acc[15:5]};
                next_gong_acc = wide_gong[16] ? `GONG_MAX : wide_gong[15:0];
            end else begin
                next_gong_acc = gong_acc - {5'h00, gong_acc[15:5]};
            end
            next_amp = next_gong_acc[15:5];
        end
        `SHAPE_EXPONENTIAL: begin
            if (!dir_buf) begin
                next_amp = live_amplitude[10] ? `AMP_MAX : {live_amplitude[9:0], 1'b1};
            end else begin
                next_amp = {1'b0, live_amplitude[10:1]};
            end
        end
        default: begin
            // Reserved shape leaves the amplitude alone
            next_amp = live_amplitude;
        end
    endcase
    threshold_hit = dir_buf ? (next_amp <= threshold_buf) : (next_amp >= threshold_buf); // [RULE2]
end

// Reload point: threshold reached with envelope, or span end without it
wire env_active = env_en_buf;                                                 // [RULE16]
wire reload_point = span_done && (!env_active || threshold_hit);              // [RULE4] [RULE5]
wire start_load = may_run && !running && config_ready_bit;
wire do_load = start_load || (reload_point && config_ready_bit);              // [RULE5]
wire do_halt = (reload_point && !config_ready_bit) || !may_run;               // [RULE17]
// A stop in the same cycle as a reload wins, so no flag for a load that never lands
wire flag_set = (do_load && may_run) || (reload_point && !config_ready_bit);  // [RULE7]

// ****************************************
// Byte-split word registers
// ****************************************
split_word_reg #(
    .WIDTH(11)
) u_divider_word (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .write_high (write_hit && (reg_addr == `OFS_DIVIDER_HIGH)),
    .write_low  (write_hit && (reg_addr == `OFS_DIVIDER_LOW)),
    .wdata      (reg_wdata),
    .value      (clock_divider)                                               // [RULE18]
);

split_word_reg #(
    .WIDTH(10)
) u_tone_word (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .write_high (write_hit && (reg_addr == `OFS_TONE_HIGH)),
    .write_low  (write_hit && (reg_addr == `OFS_TONE_LOW)),
    .wdata      (reg_wdata),
    .value      (half_tone_period)                                            // [RULE14]
);

split_word_reg #(
    .WIDTH(11)
) u_amplitude_word (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .write_high (write_hit && (reg_addr == `OFS_AMP_HIGH)),
    .write_low  (write_hit && (reg_addr == `OFS_AMP_LOW)),
    .wdata      (reg_wdata),
    .value      (amplitude_config)                                            // [RULE13]
);

split_word_reg #(
    .WIDTH(11)
) u_step_word (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .write_high (write_hit && (reg_addr == `OFS_STEP_HIGH)),
    .write_low  (write_hit && (reg_addr == `OFS_STEP_LOW)),
    .wdata      (reg_wdata),
    .value      (amplitude_step)                                              // [RULE1]
);

split_word_reg #(
    .WIDTH(11)
) u_threshold_word (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .write_high (write_hit && (reg_addr == `OFS_THRESHOLD_HIGH)),
    .write_low  (write_hit && (reg_addr == `OFS_THRESHOLD_LOW)),
    .wdata      (reg_wdata),
    .value      (amplitude_threshold)                                         // [RULE2]
);

// ****************************************
// Register writes
// ****************************************
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        gen_enable <= 1'b0;
        stop_req <= 1'b0;
        config_ready_bit <= 1'b0;
        envelope_enable <= 1'b0;
        envelope_shape_select <= 2'h0;
        envelope_direction <= 1'b0;
        tone_span_length <= `RESET_BYTE;
        next_data_irq_enable <= 1'b0;
    end else if (write_hit) begin
        if (is_config_write) begin
            config_ready_bit <= 1'b0;                                         // [RULE17]
        end
        case (reg_addr)
            `OFS_CONTROL: begin
                gen_enable <= reg_wdata[`BIT_ENABLE];
                config_ready_bit <= reg_wdata[`BIT_READY];
                stop_req <= reg_wdata[`BIT_STOP];
            end
            `OFS_ENVELOPE: begin
                envelope_enable <= reg_wdata[`BIT_ENVELOPE_ENABLE];
                envelope_shape_select <= reg_wdata[`BIT_SHAPE_HI:`BIT_SHAPE_LO];
                envelope_direction <= reg_wdata[`BIT_DIRECTION];
            end
            // Word registers take their bytes in the split instances
            `OFS_SPAN_LENGTH:    tone_span_length <= reg_wdata;
            `OFS_IRQ_ENABLE:     next_data_irq_enable <= reg_wdata[`BIT_NEXT_DATA];
            default: begin
                // Read-only and unmapped offsets ignore writes
            end
        endcase
    end
end

// Hardware set wins over a software clear in the same cycle
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        next_data_ready_flag <= 1'b0;
    end else if (flag_set) begin
        next_data_ready_flag <= 1'b1;                                         // [RULE7]
    end else if (write_hit && (reg_addr == `OFS_IRQ_FLAG) && reg_wdata[`BIT_NEXT_DATA]) begin
        next_data_ready_flag <= 1'b0;                                         // [RULE8]
    end
end

// ****************************************
// Buffers, envelope and counters
// ****************************************
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        running <= 1'b0;
        env_en_buf <= 1'b0;
        shape_buf <= 2'h0;
        dir_buf <= 1'b0;
        divider_buf <= `RESET_WORD11;
        tone_buf <= 10'h000;
        live_amplitude <= `RESET_WORD11;
        step_buf <= `RESET_WORD11;
        threshold_buf <= `RESET_WORD11;
        span_buf <= `RESET_BYTE;
        gong_acc <= 16'h0000;
        divider_count <= `RESET_WORD11;
        tone_count <= 10'h000;
        tone_level <= 1'b0;
        tone_span_counter <= `RESET_BYTE;
    end else if (do_halt) begin
        running <= 1'b0;
        divider_count <= `RESET_WORD11;
        tone_count <= 10'h000;
        tone_level <= 1'b0;
        tone_span_counter <= `RESET_BYTE;                                     // [RULE11]
        // The step that reaches the threshold still lands before a stop for a cleared ready bit, not when may_run is low
        if (reload_point && env_active && may_run) begin
            live_amplitude <= next_amp;                                       // [RULE4] [RULE9]
            gong_acc <= next_gong_acc;
        end
    end else if (do_load) begin
        // Every buffer takes its register together, counters restart
        running <= 1'b1;
        env_en_buf <= envelope_enable;
        shape_buf <= envelope_shape_select;
        dir_buf <= envelope_direction;
        divider_buf <= clock_divider;
        tone_buf <= half_tone_period;
        live_amplitude <= amplitude_config;                                   // [RULE9] [RULE13]
        step_buf <= amplitude_step;
        threshold_buf <= amplitude_threshold;
        span_buf <= tone_span_length;
        gong_acc <= {amplitude_config, envelope_direction ? 5'h1f : 5'h00};
        divider_count <= `RESET_WORD11;
        tone_count <= 10'h000;
        tone_level <= 1'b0;
        tone_span_counter <= `RESET_BYTE;
    end else if (running) begin
        divider_count <= divider_tick ? `RESET_WORD11 : divider_count + 11'h001; // [RULE18]
        if (divider_tick) begin
            tone_count <= tone_wrap ? 10'h000 : tone_count + 10'h001;        // [RULE14]
        end
        if (tone_wrap) begin
            tone_level <= ~tone_level;                                        // [RULE14]
        end
        if (tone_fall) begin
            tone_span_counter <= span_done ? `RESET_BYTE : tone_span_counter + 8'h01; // [RULE10] [RULE11]
        end
        if (span_done && env_active) begin
            live_amplitude <= next_amp;                                       // [RULE4] [RULE9]
            gong_acc <= next_gong_acc;
        end
    end
end

// ****************************************
// Outputs and read-back
// ****************************************
// Counter never exceeds the divider, so a buffer above it yields full duty
assign amp_pwm = running && (divider_count < live_amplitude);                 // [RULE12] [RULE9]
assign tone_out = tone_level;
assign running_out = running;
assign irq = next_data_irq_enable && next_data_ready_flag;                    // [RULE6]

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        reg_rdata <= `RESET_BYTE;
    end else if (reg_read) begin
        case (reg_addr)
            `OFS_CONTROL:        reg_rdata <= {gen_enable, 5'h00, config_ready_bit, stop_req};
            `OFS_ENVELOPE:       reg_rdata <= {envelope_enable, 4'h0, envelope_shape_select, envelope_direction};
            `OFS_DIVIDER_HIGH:   reg_rdata <= {5'h00, clock_divider[10:8]};
            `OFS_DIVIDER_LOW:    reg_rdata <= clock_divider[7:0];
            `OFS_TONE_HIGH:      reg_rdata <= {6'h00, half_tone_period[9:8]};
            `OFS_TONE_LOW:       reg_rdata <= half_tone_period[7:0];
            `OFS_AMP_HIGH:       reg_rdata <= {5'h00, amplitude_config[10:8]};
            `OFS_AMP_LOW:        reg_rdata <= amplitude_config[7:0];
            `OFS_STEP_HIGH:      reg_rdata <= {5'h00, amplitude_step[10:8]};
            `OFS_STEP_LOW:       reg_rdata <= amplitude_step[7:0];
            `OFS_THRESHOLD_HIGH: reg_rdata <= {5'h00, amplitude_threshold[10:8]};
            `OFS_THRESHOLD_LOW:  reg_rdata <= amplitude_threshold[7:0];
            `OFS_SPAN_LENGTH:    reg_rdata <= tone_span_length;
            `OFS_IRQ_ENABLE:     reg_rdata <= {7'h00, next_data_irq_enable};
            `OFS_IRQ_FLAG:       reg_rdata <= {7'h00, next_data_ready_flag};
            `OFS_LIVE_AMP_HIGH:  reg_rdata <= {5'h00, live_amplitude[10:8]};
            `OFS_LIVE_AMP_LOW:   reg_rdata <= live_amplitude[7:0];
            `OFS_SPAN_COUNTER:   reg_rdata <= tone_span_counter;
            default:             reg_rdata <= `RESET_BYTE;
        endcase
    end else begin
        reg_rdata <= `RESET_BYTE;
    end
end

endmodule // sound_amplitude_tone_gen

// ****************************************
// Byte-split word register
// ****************************************
// Bits above the low byte sit in the low bits of the high byte; the rest of that byte is dropped
module split_word_reg #(
    parameter WIDTH = 11
) (
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire             write_high,
    input  wire             write_low,
    input  wire [7:0]       wdata,
    output reg  [WIDTH-1:0] value
);

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        value <= {WIDTH{1'b0}};
    end else if (write_high) begin
        value[WIDTH-1:8] <= wdata[WIDTH-9:0];
    end else if (write_low) begin
        value[7:0] <= wdata;
    end
end

endmodule // split_word_reg

// >>> tb/sound_gen_chk.sv
module sound_gen_chk #(
    parameter ADDR_W = 5
) (
    input logic              sys_clk,
    input logic              reset_n,
    input logic [ADDR_W-1:0] reg_addr,
    input logic [7:0]        reg_wdata,
    input logic              reg_write,
    input logic              reg_read,
    input logic [7:0]        reg_rdata,
    input logic              irq,
    input logic              amp_pwm,
    input logic              tone_out,
    input logic              running_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Shadow of the control bits seen on the bus
    // ****************************************
    logic ie_bit, c_en, c_rdy, c_stp;
    wire  go = c_en & c_rdy & ~c_stp;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ie_bit <= 1'b0;
            c_en   <= 1'b0;
            c_rdy  <= 1'b0;
            c_stp  <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == 5'h0d) ie_bit <= reg_wdata[0];
            if (reg_addr == 5'h00) begin
                c_en  <= reg_wdata[7];
                c_rdy <= reg_wdata[1];
                c_stp <= reg_wdata[0];
            end else if (reg_addr >= 5'h01 && reg_addr <= 5'h0c) c_rdy <= 1'b0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    irq_gate_a: assert property (irq |-> ie_bit) else $error("irq without enable");
    flag_clear_a: assert property (reg_write && reg_addr == 5'h0e && reg_wdata[0] && !running_out && !go
        |=> !irq) else $error("flag not cleared");
    flag_keep_a: assert property (reg_write && reg_addr == 5'h0e && !reg_wdata[0] && irq
        |=> irq) else $error("flag lost on zero write");
    pwm_idle_a: assert property (!running_out |-> !amp_pwm) else $error("pwm while idle");
    tone_idle_a: assert property (!running_out |-> !tone_out) else $error("tone while idle");
    start_flag_a: assert property (!running_out && go && ie_bit && !reg_write
        |=> running_out && irq) else $error("load without flag");
    start_gate_a: assert property ($rose(running_out) |-> $past(go)) else $error("start without ready");
    stop_now_a: assert property (reg_write && reg_addr == 5'h00 && reg_wdata[0]
        |-> ##2 !running_out) else $error("stop ignored");
    idle_count_a: assert property (reg_read && reg_addr == 5'h12 && !running_out
        |=> reg_rdata == 8'h00) else $error("span count while idle");
endmodule // sound_gen_chk

bind sound_amplitude_tone_gen sound_gen_chk #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .amp_pwm(amp_pwm), .tone_out(tone_out), .running_out(running_out));

// >>> tb/sound_sink_model.sv
// ****************************************
// Listener on the sound pins: times tone halves and PWM high time
// ****************************************
module sound_sink_model (
    input  logic sys_clk,
    input  logic tone_out,
    input  logic amp_pwm,
    output int   half_len,
    output int   pwm_high
);
    timeunit 1ns;
    timeprecision 1ps;
    int   run = 0;
    int   hi = 0;
    logic last = 1'b0;
    // Any whole tone half spans whole PWM periods, so the high count needs no phase alignment
    always @(posedge sys_clk) begin
        if (tone_out !== last) begin
            half_len <= run;
            pwm_high <= hi;
            run      <= 1;
            hi       <= int'(amp_pwm);
        end else begin
            run <= run + 1;
            hi  <= hi + int'(amp_pwm);
        end
        last <= tone_out;
    end
endmodule // sound_sink_model

// >>> tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [7:0] reg_rdata, d;
    logic       irq, amp_pwm, tone_out, running_out;
    int         half_len, pwm_high, error_cnt = 0, check_count = 0;
    // Address, write data, expected read back
    logic [23:0] rows [11] = '{24'h08ff07, 24'h09a5a5, 24'h0afe06, 24'h0b3c3c, 24'h0c8181, 24'h0d0101,
                               24'h105500, 24'h115500, 24'h125500, 24'h0f5500, 24'h1f5500};
    always #5 sys_clk = ~sys_clk;
    sound_amplitude_tone_gen u_sound_amplitude_tone_gen (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq(irq), .amp_pwm(amp_pwm), .tone_out(tone_out), .running_out(running_out));
    sound_sink_model u_sound_sink_model (.sys_clk(sys_clk), .tone_out(tone_out), .amp_pwm(amp_pwm),
        .half_len(half_len), .pwm_high(pwm_high));
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Bounded wait for the running flag, so a dead generator cannot hang the run
    task automatic wait_run(input logic v);
        for (int n = 0; n < 300 && running_out !== v; n++) @(posedge sys_clk);
        #1 chk("running", {7'h00, running_out}, {7'h00, v});
    endtask
    // One envelope runs until its threshold stops the generator, then the live amplitude is read
    task automatic env_run(input logic [7:0] env, input logic [7:0] amp, input logic [7:0] thr,
                           input logic [7:0] exp);
        wr(5'h07, amp);
        wr(5'h0b, thr);
        wr(5'h01, env);
        wr(5'h00, 8'h82);
        wait_run(1'b1);
        wr(5'h00, 8'h80);
        wait_run(1'b0);
        rd(5'h11, d);
        chk("envelope amp", d, exp);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200us;
        error_cnt++;
        finish_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 chk("idle pins", {5'h00, irq, amp_pwm, tone_out}, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][20:16], rows[i][15:8]);
            rd(rows[i][20:16], d);
            chk("reg", d, rows[i][7:0]);
        end
        // Divider 3, tone 1, amplitude 2, span of two tone cycles, no envelope
        wr(5'h03, 8'h03); wr(5'h05, 8'h01); wr(5'h07, 8'h02); wr(5'h0c, 8'h01); wr(5'h01, 8'h00);
        wr(5'h00, 8'h82);
        wait_run(1'b1);
        chk("irq on load", {7'h00, irq}, 8'h01);
        wr(5'h0e, 8'h00);
        #1 chk("irq zero write", {7'h00, irq}, 8'h01);
        wr(5'h0e, 8'h01);
        @(posedge sys_clk);
        #1 chk("irq cleared", {7'h00, irq}, 8'h00);
        rd(5'h11, d);
        chk("live amp", d, 8'h02);
        repeat (20) @(posedge sys_clk);
        chk("tone half", half_len[7:0], 8'h08);
        chk("pwm high", pwm_high[7:0], 8'h04);
        wr(5'h07, 8'h05);
        rd(5'h11, d);
        chk("amp held", d, 8'h02);
        wait_run(1'b0);
        chk("irq on stop", {7'h00, irq}, 8'h01);
        rd(5'h12, d);
        chk("span cnt", d, 8'h00);
        wr(5'h0e, 8'h01);
        // Envelopes: one tone cycle a span, step 3, upper step and threshold bits cleared
        wr(5'h08, 8'h00);
        wr(5'h09, 8'h03);
        wr(5'h0a, 8'h00);
        wr(5'h0c, 8'h00);
        env_run(8'h80, 8'h02, 8'h08, 8'h08);
        env_run(8'h82, 8'h40, 8'h42, 8'h42);
        env_run(8'h85, 8'h20, 8'h04, 8'h04);
        wr(5'h0e, 8'h01);
        #1 chk("irq end", {7'h00, irq}, 8'h00);
        // Mid-run reset clears pins and buffers
        wr(5'h00, 8'h82);
        wait_run(1'b1);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 chk("reset pins", {4'h0, irq, amp_pwm, tone_out, running_out}, 8'h00);
        rd(5'h11, d);
        chk("reset amp", d, 8'h00);
        wr(5'h00, 8'h01);
        repeat (3) @(posedge sys_clk);
        finish_test();
    end
endmodule // tb
